// ### logic/frame_codec_pkg.sv
// package for the command frame codec: sizes, status codes, carriers
// assumes one clock domain and byte-wide streams on both link sides
// Function
// - a command body is command code, type, motor/bank selector and a four-byte value, seven bytes.
// - on serial or USB a command is nine bytes: address, seven-byte body, checksum.
// - serial command order is address, command, type, selector, value MSB first, checksum.
// - the command checksum is the 8-bit sum of all preceding bytes including the address.
// - a serial reply is reply address, module address, status, command, value MSB first, checksum.
// - the reply checksum is the 8-bit sum of all other reply bytes, sent last.
// - over CAN a command carries neither address nor checksum byte.
// - over CAN a reply carries neither address nor checksum byte.
// - each fully processed command is answered by exactly one reply.
// - the device never transmits unless answering a received command.
// - status 100 reports a command executed without error.
// - status codes are 100, 101, 1, 2, 3, 4, 5 and 6 with their fixed meanings.
package frame_codec_pkg;
    localparam int BODY_LEN   = 7;
    localparam int SER_LEN    = 9;
    localparam int CNT_W      = 4;
    localparam logic [7:0] ST_OK        = 8'h64;
    localparam logic [7:0] ST_STORED    = 8'h65;
    localparam logic [7:0] ST_BAD_CSUM  = 8'h01;
    localparam logic [7:0] ST_BAD_CMD   = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    localparam logic [7:0] ST_LOCKED    = 8'h05;
    localparam logic [7:0] ST_NO_CMD    = 8'h06;
    localparam logic [7:0] MOD_ADDR_RST   = 8'h01;
    localparam logic [7:0] REPLY_ADDR_RST = 8'h02;
    localparam int BUF_DEPTH  = 2;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  kind;
        logic [7:0]  select;
        logic [31:0] value;
    } cmd_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [31:0] value;
    } rsp_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } byte_t;
endpackage

// ### logic/csum_acc.sv
// running 8-bit additive checksum
// assumes clear and add never needed in the same cycle except restart
`timescale 1ns/1ps
module csum_acc (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clear,
    input  wire logic       add,
    input  wire logic [7:0] data,
    output logic [7:0]      sum
);
    import frame_codec_pkg::*;
    logic [7:0] sum_r;

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            sum_r <= 8'h00;
        end else if (add) begin
            sum_r <= sum_r + data;
        end
    end

    assign sum = sum_r;
endmodule // csum_acc

// ### logic/byte_buf2.sv
// two-entry byte buffer with valid/ready on both sides
// assumes the drain side may stall for any length
`timescale 1ns/1ps
module byte_buf2 (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  inValid,
    output logic                       inReady,
    input  wire frame_codec_pkg::byte_t inData,
    output logic                       outValid,
    input  wire logic                  outReady,
    output frame_codec_pkg::byte_t     outData
);
    import frame_codec_pkg::*;
    byte_t      mem_r [BUF_DEPTH];
    logic       wrPtr_r;
    logic       rdPtr_r;
    logic [1:0] count_r;
    logic       push;
    logic       pop;

    assign inReady  = (count_r != 2'd2);
    assign outValid = (count_r != 2'd0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem_r[rdPtr_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'd0;
        end else begin
            if (push) begin
                wrPtr_r <= ~wrPtr_r;
            end
            if (pop) begin
                rdPtr_r <= ~rdPtr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // byte_buf2

// ### logic/motion_command_frame_codec.sv
// command frame codec: receives, checks and decodes frames, builds one reply each except for serial frames to another address
// assumes byte streams from a UART/USB/CAN front end; canMode is steady between frames
`timescale 1ns/1ps
module motion_command_frame_codec (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   canMode,
    input  wire logic [7:0]             moduleAddr,
    input  wire logic [7:0]             replyAddr,
    input  wire logic                   rxValid,
    input  wire logic [7:0]             rxData,
    output logic                        rxReady,
    input  wire logic                   rxAbort,
    output logic                        cmdValid,
    output frame_codec_pkg::cmd_t       cmdOut,
    input  wire logic                   rspValid,
    input  wire frame_codec_pkg::rsp_t  rspIn,
    output logic                        rspReady,
    output logic                        txValid,
    output logic [7:0]                  txData,
    output logic                        txLast,
    input  wire logic                   txReady,
    output logic                        csumError,
    output logic                        busy
);
    import frame_codec_pkg::*;

    typedef enum {
        S_RX,
        S_EXEC,
        S_TX
    } state_t;

    state_t           state_r;
    logic [CNT_W-1:0] rxCnt_r;
    logic [CNT_W-1:0] txCnt_r;
    logic [7:0]       frame_r [SER_LEN];
    logic             addrMatch_r;
    logic             badCsum_r;
    cmd_t             cmd_r;
    rsp_t             rsp_r;
    logic             csumErr_r;
    logic [7:0]       rxSum;
    logic [7:0]       txSum;
    logic             rxTake;
    logic             rxLastByte;
    logic [CNT_W-1:0] rxLen;
    logic [CNT_W-1:0] txLen;
    logic [7:0]       txByte;
    logic             bufInValid;
    logic             bufInReady;
    byte_t            bufIn;
    byte_t            bufOut;
    logic             bufPush;

    function automatic logic [7:0] valByte(input logic [31:0] v, input logic [1:0] idx);
        valByte = v[31 - 8*idx -: 8];
    endfunction

    assign rxLen      = canMode ? CNT_W'(BODY_LEN) : CNT_W'(SER_LEN);
    assign txLen      = canMode ? CNT_W'(BODY_LEN - 1) : CNT_W'(SER_LEN);
    assign rxReady    = (state_r == S_RX);
    assign rxTake     = rxValid && rxReady;
    assign rxLastByte = rxTake && (rxCnt_r == rxLen - CNT_W'(1));

    csum_acc u_rx_sum (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clear   (rxLastByte || rxAbort),
        .add     (rxTake && !rxLastByte),
        .data    (rxData),
        .sum     (rxSum)
    );

    // receive path
    always_ff @(posedge clk) begin
        if (sys_rst || rxAbort) begin
            rxCnt_r <= '0;
        end else if (rxTake) begin
            rxCnt_r <= rxLastByte ? '0 : rxCnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rxTake) begin
            frame_r[rxCnt_r] <= rxData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addrMatch_r <= 1'b0;
            badCsum_r   <= 1'b0;
        end else if (rxLastByte) begin
            addrMatch_r <= canMode || (frame_r[0] == moduleAddr);
            badCsum_r   <= !canMode && (rxData != rxSum);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            csumErr_r <= 1'b0;
        end else begin
            csumErr_r <= rxLastByte && !canMode && (rxData != rxSum)
                         && (frame_r[0] == moduleAddr);
        end
    end

    // frame sequencing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= S_RX;
        end else begin
            case (state_r)
                S_RX: begin
                    if (rxLastByte && !rxAbort) begin
                        state_r <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    if (!addrMatch_r) begin
                        state_r <= S_RX;
                    end else if (badCsum_r || rspValid) begin
                        state_r <= S_TX;
                    end
                end
                S_TX: begin
                    if (bufPush && txCnt_r == txLen - CNT_W'(1)) begin
                        state_r <= S_RX;
                    end
                end
                default: state_r <= S_RX;
            endcase
        end
    end

    // decoded command towards the execution logic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_r <= '0;
        end else begin
            if (rxLastByte && !rxAbort) begin
                if (canMode) begin
                    cmd_r <= {frame_r[0], frame_r[1], frame_r[2], frame_r[3],
                              frame_r[4], frame_r[5], rxData};
                end else begin
                    cmd_r <= {frame_r[1], frame_r[2], frame_r[3], frame_r[4],
                              frame_r[5], frame_r[6], frame_r[7]};
                end
            end
        end
    end

    assign cmdValid = (state_r == S_EXEC) && addrMatch_r && !badCsum_r;
    assign cmdOut   = cmd_r;
    assign rspReady = cmdValid;

    // reply capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_r <= '0;
        end else if (state_r == S_EXEC && addrMatch_r) begin
            if (badCsum_r) begin
                rsp_r <= '{status: ST_BAD_CSUM, value: 32'h0000_0000};
            end else if (rspValid) begin
                rsp_r <= rspIn;
            end
        end
    end

    // reply serialiser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txCnt_r <= '0;
        end else if (state_r != S_TX) begin
            txCnt_r <= '0;
        end else if (bufPush) begin
            txCnt_r <= txCnt_r + CNT_W'(1);
        end
    end

    always_comb begin
        txByte = 8'h00;
        if (canMode) begin
            case (txCnt_r)
                4'd0:    txByte = rsp_r.status;
                4'd1:    txByte = cmd_r.opcode;
                4'd2:    txByte = valByte(rsp_r.value, 2'd0);
                4'd3:    txByte = valByte(rsp_r.value, 2'd1);
                4'd4:    txByte = valByte(rsp_r.value, 2'd2);
                4'd5:    txByte = valByte(rsp_r.value, 2'd3);
                default: txByte = 8'h00;
            endcase
        end else begin
            case (txCnt_r)
                4'd0:    txByte = replyAddr;
                4'd1:    txByte = moduleAddr;
                4'd2:    txByte = rsp_r.status;
                4'd3:    txByte = cmd_r.opcode;
                4'd4:    txByte = valByte(rsp_r.value, 2'd0);
                4'd5:    txByte = valByte(rsp_r.value, 2'd1);
                4'd6:    txByte = valByte(rsp_r.value, 2'd2);
                4'd7:    txByte = valByte(rsp_r.value, 2'd3);
                4'd8:    txByte = txSum;
                default: txByte = 8'h00;
            endcase
        end
    end

    csum_acc u_tx_sum (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clear   (state_r != S_TX),
        .add     (bufPush),
        .data    (txByte),
        .sum     (txSum)
    );

    assign bufInValid = (state_r == S_TX);
    assign bufPush    = bufInValid && bufInReady;
    assign bufIn      = '{data: txByte, last: (txCnt_r == txLen - CNT_W'(1))};

    byte_buf2 u_tx_buf (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inValid  (bufInValid),
        .inReady  (bufInReady),
        .inData   (bufIn),
        .outValid (txValid),
        .outReady (txReady),
        .outData  (bufOut)
    );

    assign txData    = bufOut.data;
    assign txLast    = bufOut.last;
    assign csumError = csumErr_r;
    assign busy      = (state_r != S_RX);
endmodule // motion_command_frame_codec

// ### dv/codec_monitor.sv
// codec port checker: handshakes, reply count, checksum pulse
// assumes one clock, sync active-high reset
`timescale 1ns/1ps
module codec_monitor (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic                  canMode,
    input wire logic [7:0]            moduleAddr,
    input wire logic [7:0]            replyAddr,
    input wire logic                  rxValid,
    input wire logic [7:0]            rxData,
    input wire logic                  rxReady,
    input wire logic                  rxAbort,
    input wire logic                  cmdValid,
    input wire frame_codec_pkg::cmd_t cmdOut,
    input wire logic                  rspValid,
    input wire frame_codec_pkg::rsp_t rspIn,
    input wire logic                  rspReady,
    input wire logic                  txValid,
    input wire logic [7:0]            txData,
    input wire logic                  txLast,
    input wire logic                  txReady,
    input wire logic                  csumError,
    input wire logic                  busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [1:0] owed_r;
    // replies owed
    always_ff @(posedge clk) begin
        if (sys_rst) owed_r <= 2'h0;
        else owed_r <= owed_r + 2'(rspValid && rspReady || csumError)
                              - 2'(txValid && txReady && txLast);
    end
    sequence s_rspTaken; rspValid && rspReady && !canMode; endsequence
    sequence s_firstByte; ##[1:6] (txValid && txData == replyAddr); endsequence
    property p_owed; txValid |-> owed_r != 2'h0; endproperty
    property p_one; owed_r <= 2'h1; endproperty
    property p_txHold; txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast); endproperty
    property p_cmdHold; cmdValid && !rspValid |=> cmdValid && $stable(cmdOut); endproperty
    property p_rspReady; rspReady == cmdValid; endproperty
    property p_cmdBusy; cmdValid |-> !rxReady && busy; endproperty
    property p_badSum; csumError |-> !cmdValid ##1 (!csumError && !cmdValid)[*4]; endproperty
    property p_first; s_rspTaken |-> s_firstByte; endproperty
    property p_canSum; canMode |-> !csumError; endproperty
    a_owed: assert property (p_owed) else $error("unsolicited reply byte");
    a_one: assert property (p_one) else $error("more than one reply owed");
    a_txHold: assert property (p_txHold) else $error("reply byte moved in stall");
    a_cmdHold: assert property (p_cmdHold) else $error("command dropped early");
    a_rspReady: assert property (p_rspReady) else $error("rspReady not cmdValid");
    a_cmdBusy: assert property (p_cmdBusy) else $error("rx open during command");
    a_badSum: assert property (p_badSum) else $error("bad sum executed");
    a_first: assert property (p_first) else $error("reply address missing");
    a_canSum: assert property (p_canSum) else $error("checksum fault in CAN");
endmodule // codec_monitor
bind motion_command_frame_codec codec_monitor codec_monitor_i (.clk, .sys_rst, .canMode,
    .moduleAddr, .replyAddr, .rxValid, .rxData, .rxReady, .rxAbort, .cmdValid, .cmdOut,
    .rspValid, .rspIn, .rspReady, .txValid, .txData, .txLast, .txReady, .csumError, .busy);

// ### dv/reply_sink.sv
// host side: gathers reply bytes, may stall every other cycle
// assumes the bench reads got and frames
`timescale 1ns/1ps
module reply_sink (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       slow,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    input  wire logic       txLast,
    output logic            txReady
);
    logic [7:0] got[$];
    int         frames = 0;
    initial txReady = 1'b1;
    always @(posedge clk) begin
        if (txValid && txReady) begin
            got.push_back(txData);
            if (txLast) frames++;
        end
        txReady <= sys_rst || !slow || !txReady;
    end
endmodule // reply_sink

// ### dv/motion_command_frame_codec_test.sv
// bench: serial, CAN with all status codes, bad sum, foreign address
// assumes reply_sink on the reply stream, checker bound in
`timescale 1ns/1ps
module motion_command_frame_codec_test;
    import frame_codec_pkg::*;
    logic       clk, sys_rst, canMode, rxValid, rxAbort, rspValid, slow, rxReady;
    logic       cmdValid, rspReady, txValid, txLast, txReady, csumError, busy;
    logic [7:0] moduleAddr, replyAddr, rxData, txData;
    cmd_t       cmdOut;
    rsp_t       rspIn;
    logic [7:0] exp[$];
    int         mismatches = 0;
    int         total_checks = 0;
    int         cyc = 0;
    motion_command_frame_codec motion_command_frame_codec_i (.clk, .sys_rst, .canMode,
        .moduleAddr, .replyAddr, .rxValid, .rxData, .rxReady, .rxAbort, .cmdValid, .cmdOut,
        .rspValid, .rspIn, .rspReady, .txValid, .txData, .txLast, .txReady, .csumError, .busy);
    reply_sink reply_sink_i (.clk, .sys_rst, .slow, .txValid, .txData, .txLast, .txReady);
    task automatic chk(string what, logic [63:0] e, logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic put(logic [7:0] b);
        rxValid <= 1'b1;
        rxData <= b;
        do @(posedge clk); while (rxReady !== 1'b1);
    endtask
    task automatic frame(logic [7:0] adr, cmd_t c, logic bad);
        logic [7:0] b[$];
        logic [7:0] s;
        b = {c.opcode, c.kind, c.select, c.value[31:24], c.value[23:16], c.value[15:8], c.value[7:0]};
        if (!canMode) begin
            b.push_front(adr);
            s = 8'h00;
            foreach (b[i]) s += b[i];
            b.push_back(s ^ {7'h00, bad});
        end
        foreach (b[i]) put(b[i]);
        rxValid <= 1'b0;
    endtask
    task automatic take_reply(logic [7:0] st, logic [7:0] op, logic [31:0] v);
        logic [7:0] s;
        int n;
        exp = {st, op, v[31:24], v[23:16], v[15:8], v[7:0]};
        if (!canMode) begin
            exp = {replyAddr, moduleAddr, exp};
            s = 8'h00;
            foreach (exp[i]) s += exp[i];
            exp.push_back(s);
        end
        n = reply_sink_i.frames;
        repeat (200) if (reply_sink_i.frames == n) @(posedge clk);
        chk("reply count", n + 1, reply_sink_i.frames);
        chk("reply length", exp.size(), reply_sink_i.got.size());
        foreach (exp[i]) chk("reply byte", exp[i], reply_sink_i.got[i]);
        reply_sink_i.got.delete();
    endtask
    task automatic exec(cmd_t c, logic [7:0] st, logic [31:0] v);
        int n = 0;
        while (cmdValid !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("command", c, cmdOut);
        rspValid <= 1'b1;
        rspIn <= '{st, v};
        @(posedge clk);
        rspValid <= 1'b0;
        take_reply(st, c.opcode, v);
    endtask
    task automatic t_serial();
        cmd_t c = '{8'h05, 8'h04, 8'h00, 32'h0000c800};
        frame(moduleAddr, c, 1'b0);
        exec(c, ST_OK, 32'h89abcdef);
        c = '{8'h04, 8'h00, 8'h02, 32'hfff83000};
        frame(moduleAddr, c, 1'b0);
        exec(c, ST_STORED, 32'h00000000);
        $display("serial done");
    endtask
    task automatic t_can();
        logic [7:0] codes[8] = '{ST_OK, ST_STORED, ST_BAD_CSUM, ST_BAD_CMD,
                                 ST_BAD_TYPE, ST_BAD_VALUE, ST_LOCKED, ST_NO_CMD};
        cmd_t c;
        canMode <= 1'b1;
        @(posedge clk);
        foreach (codes[i]) begin
            slow <= i[0];
            c = '{i[7:0] + 8'h01, 8'hff, i[7:0], {4{i[7:0]}}};
            frame(8'h00, c, 1'b0);
            exec(c, codes[i], 32'h80000001 + i);
        end
        slow <= 1'b0;
        canMode <= 1'b0;
        @(posedge clk);
        $display("can done");
    endtask
    task automatic t_bad();
        cmd_t c = '{8'h06, 8'h01, 8'h00, 32'h00000007};
        frame(moduleAddr, c, 1'b1);
        chk("cmdValid on bad sum", 0, cmdValid);
        @(posedge clk);
        chk("csumError", 1, csumError);
        chk("busy after bad frame", 1, busy);
        chk("cmdValid after bad sum", 0, cmdValid);
        take_reply(ST_BAD_CSUM, c.opcode, 32'h0);
        $display("bad sum done");
    endtask
    task automatic t_foreign();
        cmd_t c = '{8'h01, 8'h00, 8'h00, 32'h00000010};
        int n = reply_sink_i.frames;
        put(moduleAddr);
        put(8'h01);
        rxValid <= 1'b0;
        rxAbort <= 1'b1;
        @(posedge clk);
        rxAbort <= 1'b0;
        frame(moduleAddr + 8'h01, c, 1'b0);
        repeat (30) @(posedge clk);
        chk("foreign replies", n, reply_sink_i.frames);
        chk("rxReady after drop", 1, rxReady);
        frame(moduleAddr, c, 1'b0);
        exec(c, ST_BAD_CMD, 32'h0);
        $display("foreign done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        {sys_rst, canMode, rxValid, rxAbort, rspValid, slow} = 6'b100000;
        {moduleAddr, replyAddr, rxData, rspIn} = {8'h05, 8'h02, 8'h00, 40'h0};
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("txValid after reset", 0, txValid);
        t_serial();
        t_can();
        t_bad();
        t_foreign();
        stop_test();
    end
endmodule // motion_command_frame_codec_test
